// ==== core/shpi_port.sv ====
// Serial host port: SPI slave, interrupt registers and status registers
//
// Summary of operation
// - Interrupt pin low while any first-level bit set
// - First-level bit clears with its source register
// - System reset or block reset clears interrupts
// - Pin held high release time after clear
// - Pending interrupt returns pin low after release
// - Writing one clears source bit, zero keeps
// - Two levels: region register, per-region sources
// - Events during a read stay pending
// - Status registers show live flags anytime
// - Reset cause captured when reset pin falls
// - Reset reason cleared after completed read
// - Select low means SPI, high two-wire
// - Interface switch within eight microseconds
// - Clock and data pins shared with two-wire
// - Half-duplex slave, master starts every transfer
// - Clock level at select fall sets edges
// - Read data driven MSB first after header
// - Select rising edge ends the operation
`timescale 1ns/1ns
module shpi_port #(
  parameter int RELEASE_CYCLES = shpi_pkg::IRQ_RELEASE_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic iface_sel_in,
  input wire logic sys_reset_n_in,
  input wire logic reset_pin_n_in,
  input wire logic [7:0] reset_cause_in,
  input wire shpi_pkg::shpi_region_type event_in,
  input wire shpi_pkg::shpi_region_type flag_in,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  output logic irq_out_n,
  output logic [2:0] irq_top_out,
  output logic twowire_mode_out,
  output logic twi_scl_out,
  output logic twi_sda_out
);
  localparam int REL_W = $clog2(RELEASE_CYCLES + 1);

  // Synchronised pins and their previous values
  logic [2:0] pins_sync;
  logic s_cs_n, s_sclk, s_sdi;
  logic prev_cs_n, prev_sclk;
  // Clock polarity caught at select fall
  logic pol;
  // Frame tracking
  shpi_pkg::shpi_state_type state;
  logic [4:0] bit_cnt;
  logic [7:0] shreg;
  logic hdr_rw;
  logic [4:0] hdr_addr;
  logic [7:0] sh_out;
  // Register storage
  shpi_pkg::shpi_region_type src;
  logic [7:0] reset_reason;
  logic [2:0] irq_top;
  logic [REL_W-1:0] rel_cnt;
  logic prev_reset_pin_n;
  // Select pin synchroniser stages
  logic mode_meta, pins_mode_sync;
  // Decoded strobes
  logic cs_fall, cs_rise, sample_edge, shift_edge, spi_en;
  logic rd_load, wr_commit, rd_done, rel_load, rr_fall;
  logic [7:0] rd_value;
  shpi_pkg::shpi_region_type clr;

  // Write-one-to-clear with set winning over clear
  function automatic logic [7:0] w1c_next(input logic [7:0] cur, input logic [7:0] set,
                                         input logic [7:0] wclr);
    w1c_next = (cur & ~wclr) | set;
  endfunction : w1c_next

  // Serial select, clock and data pins cross into the clock domain before any logic reads them
  shpi_sync #(.WIDTH(3), .RESET_VAL(shpi_pkg::PIN_SYNC_RESET)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({cs_n_in, sclk_in, sdi_in}),
    .sync_out(pins_sync)
  );
  assign s_cs_n = pins_sync[2];
  assign s_sclk = pins_sync[1];
  assign s_sdi = pins_sync[0];

  // Edge history of the synchronised pins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_cs_n <= 1'b1;
      prev_sclk <= 1'b0;
    end else begin
      prev_cs_n <= s_cs_n;
      prev_sclk <= s_sclk;
    end
  end

  // Interface select follows the pin three cycles later, far inside the limit
  // mode from select pin
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      twowire_mode_out <= 1'b0;
    end else begin
      twowire_mode_out <= pins_mode_sync;
    end
  end
  // Select pin has its own two flops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_meta <= 1'b0;
      pins_mode_sync <= 1'b0;
    end else begin
      mode_meta <= iface_sel_in;
      pins_mode_sync <= mode_meta;
    end
  end
  assign spi_en = !twowire_mode_out;

  // Shared pins handed to the two-wire engine only in that mode
  // shared pin routing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      twi_scl_out <= 1'b0;
      twi_sda_out <= 1'b0;
    end else begin
      twi_scl_out <= twowire_mode_out & s_sclk;
      twi_sda_out <= twowire_mode_out & s_sdi;
    end
  end

  // Edge decode; only the master opens a frame by pulling select low
  // polarity-dependent edges
  assign cs_fall = spi_en && prev_cs_n && !s_cs_n;
  assign cs_rise = spi_en && !prev_cs_n && s_cs_n;
  assign sample_edge = spi_en && !s_cs_n && (state != shpi_pkg::SHPI_IDLE) &&
                       (pol ? (s_sclk && !prev_sclk) : (!s_sclk && prev_sclk));
  assign shift_edge = spi_en && !s_cs_n && (state != shpi_pkg::SHPI_IDLE) &&
                      (pol ? (!s_sclk && prev_sclk) : (s_sclk && !prev_sclk));

  // Header complete on the eighth sample; read bit first, then address
  // header decode
  assign rd_load = sample_edge && (state == shpi_pkg::SHPI_HEAD) &&
                   (bit_cnt == shpi_pkg::HEADER_BITS - 5'h01) && shreg[6];
  // commit only on full frame at select rise
  assign wr_commit = cs_rise && (state == shpi_pkg::SHPI_DATA) &&
                     (bit_cnt == shpi_pkg::FRAME_BITS) && !hdr_rw;
  assign rd_done = cs_rise && (state == shpi_pkg::SHPI_DATA) &&
                   (bit_cnt == shpi_pkg::FRAME_BITS) && hdr_rw;

  // Frame state, bit counter and input shift register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= shpi_pkg::SHPI_IDLE;
      bit_cnt <= 5'h00;
      shreg <= 8'h00;
      hdr_rw <= 1'b0;
      hdr_addr <= 5'h00;
      pol <= 1'b0;
    end else if (!spi_en || cs_rise) begin
      // Mode change or end of frame drops any partial frame
      state <= shpi_pkg::SHPI_IDLE;
      bit_cnt <= 5'h00;
    end else if (cs_fall) begin
      pol <= s_sclk;
      state <= shpi_pkg::SHPI_HEAD;
      bit_cnt <= 5'h00;
    end else if (sample_edge) begin
      shreg <= {shreg[6:0], s_sdi};
      case (state)
        shpi_pkg::SHPI_HEAD: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == shpi_pkg::HEADER_BITS - 5'h01) begin
            // Reserved bits are ignored
            hdr_rw <= shreg[6];
            hdr_addr <= shreg[5:1];
            state <= shpi_pkg::SHPI_DATA;
          end
        end
        shpi_pkg::SHPI_DATA: begin
          // Bits past the frame still shift into shreg; counter saturates
          if (bit_cnt != shpi_pkg::FRAME_BITS) begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        default: begin
          state <= shpi_pkg::SHPI_IDLE;
        end
      endcase
    end
  end

  // Read data mux; statuses are live flags, not stored copies
  // live status read
  always_comb begin
    case (shreg[5:1])
      shpi_pkg::ADDR_IRQ_TOP: rd_value = {5'h00, irq_top};
      shpi_pkg::ADDR_BUS_SRC: rd_value = src.bus;
      shpi_pkg::ADDR_TEMP_SRC: rd_value = src.temp;
      shpi_pkg::ADDR_SUPPLY_SRC: rd_value = src.supply;
      shpi_pkg::ADDR_BUS_STAT: rd_value = flag_in.bus;
      shpi_pkg::ADDR_TEMP_STAT: rd_value = flag_in.temp;
      shpi_pkg::ADDR_SUPPLY_STAT: rd_value = flag_in.supply;
      shpi_pkg::ADDR_RESET_REASON: rd_value = reset_reason;
      default: rd_value = shpi_pkg::REG_RESET;
    endcase
  end

  // Output shifter: a snapshot is loaded, so later events never corrupt it
  // read data MSB first
  // The MSB must stand over the first data sample, so that shift edge is skipped
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sh_out <= 8'h00;
      sdo_out <= 1'b0;
      sdo_oe_n_out <= 1'b1;
    end else if (!spi_en || cs_rise) begin
      sdo_out <= 1'b0;
      sdo_oe_n_out <= 1'b1;
    end else if (rd_load) begin
      sh_out <= rd_value;
      sdo_out <= rd_value[7];
      sdo_oe_n_out <= 1'b0;
    end else if (shift_edge && (state == shpi_pkg::SHPI_DATA) && hdr_rw &&
                 (bit_cnt != shpi_pkg::HEADER_BITS)) begin
      sh_out <= {sh_out[6:0], 1'b0};
      sdo_out <= sh_out[6];
    end
  end

  // Clear masks from a committed write; data byte is the shift register
  // write-one clear mask
  always_comb begin
    clr = '0;
    if (wr_commit) begin
      case (hdr_addr)
        shpi_pkg::ADDR_BUS_SRC: clr.bus = shreg;
        shpi_pkg::ADDR_TEMP_SRC: clr.temp = shreg;
        shpi_pkg::ADDR_SUPPLY_SRC: clr.supply = shreg;
        default: clr = '0;
      endcase
    end
  end

  // Source registers; events win over a clear in the same cycle
  // sources with reset and set priority
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      src <= '0;
    end else if (!sys_reset_n_in) begin
      src <= '0;
    end else begin
      src.bus <= w1c_next(src.bus, event_in.bus, clr.bus);
      src.temp <= w1c_next(src.temp, event_in.temp, clr.temp);
      src.supply <= w1c_next(src.supply, event_in.supply, clr.supply);
    end
  end

  // First level summarises regions, so it clears with its sources
  // two-level summary
  assign irq_top[shpi_pkg::TOP_BUS] = |src.bus;
  assign irq_top[shpi_pkg::TOP_TEMP] = |src.temp;
  assign irq_top[shpi_pkg::TOP_SUPPLY] = |src.supply;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_top_out <= 3'h0;
    end else begin
      irq_top_out <= irq_top;
    end
  end

  // Any write that actually clears a set bit restarts the release window
  // release timer
  assign rel_load = |(clr & src);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rel_cnt <= '0;
    end else if (rel_load) begin
      rel_cnt <= REL_W'(RELEASE_CYCLES);
    end else if (rel_cnt != '0) begin
      rel_cnt <= rel_cnt - REL_W'(1);
    end
  end

  // Pin low on pending interrupt outside the release window
  // interrupt pin drive
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= !((|irq_top) && (rel_cnt == '0) && !rel_load);
    end
  end

  // Reset reason: capture beats a read clear arriving in the same cycle
  // capture and clear on read
  assign rr_fall = prev_reset_pin_n && !reset_pin_n_in;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_reset_pin_n <= 1'b1;
      reset_reason <= shpi_pkg::REG_RESET;
    end else begin
      prev_reset_pin_n <= reset_pin_n_in;
      if (rr_fall) begin
        reset_reason <= reset_cause_in;
      end else if (rd_done && (hdr_addr == shpi_pkg::ADDR_RESET_REASON)) begin
        reset_reason <= shpi_pkg::REG_RESET;
      end
    end
  end

  // Checks
  a_irq_pin_low: assert property (@(posedge clk_in) disable iff (rst_in)
    ((|irq_top) && rel_cnt == '0 && !rel_load) |=> !irq_out_n) else $error("irq pin not low");
  a_top_follows_src: assert property (@(posedge clk_in) disable iff (rst_in)
    (src.bus == 8'h00) |=> !irq_top_out[shpi_pkg::TOP_BUS]) else $error("top bit without source");
  a_sysrst_clears: assert property (@(posedge clk_in) disable iff (rst_in)
    !sys_reset_n_in |=> (irq_top == 3'h0)) else $error("system reset left interrupts");
  a_release_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    rel_load |=> (irq_out_n && rel_cnt == REL_W'(RELEASE_CYCLES))) else $error("release not held");
  a_release_count: assert property (@(posedge clk_in) disable iff (rst_in)
    (rel_cnt != '0 && !rel_load) |=> (irq_out_n && rel_cnt == $past(rel_cnt) - REL_W'(1)))
    else $error("release count wrong");
  a_w1c_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_commit && hdr_addr == shpi_pkg::ADDR_BUS_SRC && sys_reset_n_in) |=>
    (src.bus == (($past(src.bus) & ~$past(shreg)) | $past(event_in.bus)))) else $error("w1c wrong");
  a_event_kept: assert property (@(posedge clk_in) disable iff (rst_in)
    sys_reset_n_in |=> ((src.temp & $past(event_in.temp)) == $past(event_in.temp)))
    else $error("event lost");
  a_status_live: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_load && shreg[5:1] == shpi_pkg::ADDR_BUS_STAT) |=> (sh_out == $past(flag_in.bus)))
    else $error("status not live");
  a_reason_capture: assert property (@(posedge clk_in) disable iff (rst_in)
    rr_fall |=> (reset_reason == $past(reset_cause_in))) else $error("reset cause not captured");
  a_reason_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_done && hdr_addr == shpi_pkg::ADDR_RESET_REASON && !rr_fall) |=> (reset_reason == 8'h00))
    else $error("reset reason not cleared");
  a_mode_switch: assert property (@(posedge clk_in) disable iff (rst_in)
    ##3 (twowire_mode_out == $past(iface_sel_in, 3))) else $error("mode switch late");
  a_sdo_msb: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_load |=> (sdo_out == $past(rd_value[7]) && !sdo_oe_n_out)) else $error("read msb wrong");
  a_short_drop: assert property (@(posedge clk_in) disable iff (rst_in)
    (cs_rise && bit_cnt != shpi_pkg::FRAME_BITS && sys_reset_n_in) |=> (src == ($past(src) | $past(event_in))))
    else $error("short write taken");
  c_write: cover property (@(posedge clk_in) disable iff (rst_in) wr_commit && clr != '0);
  c_read: cover property (@(posedge clk_in) disable iff (rst_in) rd_done);
  c_release_pending: cover property (@(posedge clk_in) disable iff (rst_in)
    rel_load ##1 (|irq_top));
endmodule : shpi_port

// ==== core/shpi_sync.sv ====
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module shpi_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta;

  // Both stages reset to the idle pin level so no false edge follows reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : shpi_sync

// ==== inc/shpi_pkg.sv ====
// Constants and types shared by the serial host port with interrupt logic
package shpi_pkg;
  // Clock of the block
  localparam int CLK_PERIOD_NS = 50;
  // Least release time of the interrupt pin after a clear, in ns
  localparam int IRQ_RELEASE_TIME_NS = 50000;
  // Least time rounds up to whole cycles
  localparam int IRQ_RELEASE_CYCLES = (IRQ_RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest interface switching time, in ns
  localparam int MODE_SWITCH_TIME_NS = 8000;
  // Longest time rounds down to whole cycles
  localparam int MODE_SWITCH_CYCLES = MODE_SWITCH_TIME_NS / CLK_PERIOD_NS;
  // Frame layout
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [4:0] HEADER_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  // Register addresses
  localparam logic [4:0] ADDR_IRQ_TOP = 5'h00;
  localparam logic [4:0] ADDR_BUS_SRC = 5'h01;
  localparam logic [4:0] ADDR_TEMP_SRC = 5'h02;
  localparam logic [4:0] ADDR_SUPPLY_SRC = 5'h03;
  localparam logic [4:0] ADDR_BUS_STAT = 5'h04;
  localparam logic [4:0] ADDR_TEMP_STAT = 5'h05;
  localparam logic [4:0] ADDR_SUPPLY_STAT = 5'h06;
  localparam logic [4:0] ADDR_RESET_REASON = 5'h07;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] PIN_SYNC_RESET = 3'h4;
  // First-level bit positions
  localparam int TOP_BUS = 0;
  localparam int TOP_TEMP = 1;
  localparam int TOP_SUPPLY = 2;
  // One byte per region: bus, temperature, supply
  typedef struct packed {
    logic [7:0] supply;
    logic [7:0] temp;
    logic [7:0] bus;
  } shpi_region_type;
  // Serial port state
  typedef enum logic [1:0] {
    SHPI_IDLE,
    SHPI_HEAD,
    SHPI_DATA
  } shpi_state_type;
endpackage : shpi_pkg

// ==== verif/shpi_master.sv ====
// Serial bus master model that drives the host port of the block
`timescale 1ns/1ns
module shpi_master (
  output logic cs_n_out,
  output logic sclk_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  // Half period of the 400 ns link clock
  localparam int HALF_NS = 200;

  // Idle pins before the first frame
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end

  // Raw pin levels, used while the port runs in two-wire mode
  task automatic pins(input logic c, input logic d);
    sclk_out = c;
    sdi_out = d;
  endtask : pins

  // One frame; an nbits below 16 cuts it short on purpose
  task automatic xfer(input logic pol, input logic [15:0] frame, input int nbits, output logic [7:0] rdata);
    rdata = 8'h00;
    sclk_out = pol;
    #(HALF_NS);
    // only the master opens a frame
    cs_n_out = 1'b0;
    #(HALF_NS);
    for (int i = 0; i < nbits; i++) begin
      // Shift edge: new bit goes out
      sclk_out = !pol;
      sdi_out = frame[15 - i];
      #(HALF_NS);
      // Sample edge: read data is taken just before it
      if (i >= 8) rdata = {rdata[6:0], sdo_in};
      sclk_out = pol;
      #(HALF_NS);
    end
    // select low throughout, its rise ends the frame
    cs_n_out = 1'b1;
    // No pull on the data line, so the old bit must not linger
    sdi_out = !sdi_out;
    #(HALF_NS);
  endtask : xfer
endmodule : shpi_master

// ==== verif/shpi_port_tb_top.sv ====
// Self-checking bench for the serial host port
`timescale 1ns/1ns
module shpi_port_tb_top;
  // Short release time keeps the run brief
  localparam int REL = 8;
  logic clk_in, rst_in, cs_n, sclk, sdi, iface_sel_in, sys_reset_n_in, reset_pin_n_in;
  logic [7:0] reset_cause_in;
  shpi_pkg::shpi_region_type event_in, flag_in;
  logic sdo_out, sdo_oe_n_out, irq_out_n, twowire_mode_out, twi_scl_out, twi_sda_out;
  logic [2:0] irq_top_out;
  logic [7:0] rd_data;
  int n_mismatch = 0;
  int comparisons = 0;

  // 20 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = !clk_in;
  end

  shpi_port #(.RELEASE_CYCLES(REL)) DUT (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .sdi_in(sdi), .iface_sel_in(iface_sel_in), .sys_reset_n_in(sys_reset_n_in), .reset_pin_n_in(reset_pin_n_in),
    .reset_cause_in(reset_cause_in), .event_in(event_in), .flag_in(flag_in), .sdo_out(sdo_out),
    .sdo_oe_n_out(sdo_oe_n_out), .irq_out_n(irq_out_n), .irq_top_out(irq_top_out),
    .twowire_mode_out(twowire_mode_out), .twi_scl_out(twi_scl_out), .twi_sda_out(twi_sda_out));

  shpi_master u_master (.cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi), .sdo_in(sdo_out));

  // Counts every compare, reports a mismatch at once
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Inputs change just after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  // Bounded wait on the interrupt pin (sel 0) or the mode flag (sel 1)
  task automatic wait_for(input int sel, input logic lvl, input int bound);
    int k;
    for (k = 0; k < bound; k++) begin
      if ((sel == 1 ? twowire_mode_out : irq_out_n) === lvl) break;
      cyc(1);
    end
    check({7'h00, k < bound}, 8'h01, "bounded wait");
    if (k >= bound) give_verdict();
  endtask : wait_for

  // Write frame of nbits sample edges
  task automatic wr(input logic pol, input logic [4:0] a, input logic [7:0] d, input int nbits);
    u_master.xfer(pol, {1'b0, a, 2'b00, d}, nbits, rd_data);
    cyc(1);
  endtask : wr

  // Full read frame, then the data pin must be let go
  task automatic rd(input logic pol, input logic [4:0] a, input logic [7:0] exp, input string what);
    u_master.xfer(pol, {1'b1, a, 2'b00, 8'h00}, 16, rd_data);
    cyc(1);
    check(rd_data, exp, what);
    check({7'h00, sdo_oe_n_out}, 8'h01, "output released");
  endtask : rd

  // Main sequence
  initial begin
    rst_in = 1'b1;
    iface_sel_in = 1'b0;
    sys_reset_n_in = 1'b1;
    reset_pin_n_in = 1'b1;
    reset_cause_in = 8'h00;
    event_in = '0;
    flag_in = 24'h5a3c81;
    cyc(10);
    rst_in = 1'b0;
    cyc(4);
    check({5'h00, irq_top_out}, 8'h00, "top after reset");
    check({7'h00, irq_out_n}, 8'h01, "irq idle");
    rd(1'b1, shpi_pkg::ADDR_BUS_STAT, 8'h81, "bus status");
    rd(1'b0, shpi_pkg::ADDR_TEMP_STAT, 8'h3c, "temp status");
    flag_in.supply = 8'ha6;
    rd(1'b0, shpi_pkg::ADDR_SUPPLY_STAT, 8'ha6, "live supply status");
    rd(1'b1, 5'h1f, 8'h00, "unmapped read");
    // Two regions raise events together
    event_in.bus = 8'h12;
    event_in.temp = 8'h40;
    cyc(1);
    event_in = '0;
    cyc(3);
    check({7'h00, irq_out_n}, 8'h00, "irq asserted");
    check({5'h00, irq_top_out}, 8'h03, "top regions");
    rd(1'b1, shpi_pkg::ADDR_IRQ_TOP, 8'h03, "top register");
    // A new event lands in the data phase of a source read
    fork
      rd(1'b0, shpi_pkg::ADDR_BUS_SRC, 8'h12, "bus source");
      begin
        cyc(80);
        event_in.bus = 8'h80;
        cyc(1);
        event_in = '0;
      end
    join
    rd(1'b0, shpi_pkg::ADDR_BUS_SRC, 8'h92, "event kept pending");
    wr(1'b1, shpi_pkg::ADDR_BUS_SRC, 8'h82, 16);
    check({7'h00, irq_out_n}, 8'h01, "high after clear");
    // Clear landed two cycles ago; the pin must stay high to the end of the window
    cyc(REL - 2);
    check({7'h00, irq_out_n}, 8'h01, "held for release time");
    wait_for(0, 1'b0, 3);
    rd(1'b1, shpi_pkg::ADDR_BUS_SRC, 8'h10, "one clears, zero keeps");
    wr(1'b0, shpi_pkg::ADDR_BUS_SRC, 8'h10, 12);
    rd(1'b0, shpi_pkg::ADDR_BUS_SRC, 8'h10, "short write discarded");
    wr(1'b1, shpi_pkg::ADDR_BUS_SRC, 8'h10, 16);
    wr(1'b0, shpi_pkg::ADDR_TEMP_SRC, 8'h40, 16);
    cyc(REL + 20);
    check({7'h00, irq_out_n}, 8'h01, "stays high, nothing pending");
    check({5'h00, irq_top_out}, 8'h00, "top cleared with sources");
    // Reset pin pulse captures its cause
    reset_cause_in = 8'ha5;
    reset_pin_n_in = 1'b0;
    cyc(2);
    reset_pin_n_in = 1'b1;
    reset_cause_in = 8'h00;
    rd(1'b1, shpi_pkg::ADDR_RESET_REASON, 8'ha5, "reset cause");
    rd(1'b1, shpi_pkg::ADDR_RESET_REASON, 8'h00, "cleared by read");
    // System reset wipes a pending source
    event_in.supply = 8'h01;
    cyc(1);
    event_in = '0;
    wait_for(0, 1'b0, 5);
    sys_reset_n_in = 1'b0;
    cyc(3);
    sys_reset_n_in = 1'b1;
    wait_for(0, 1'b1, 5);
    rd(1'b0, shpi_pkg::ADDR_SUPPLY_SRC, 8'h00, "sources cleared by reset");
    // Two-wire mode and back
    iface_sel_in = 1'b1;
    wait_for(1, 1'b1, shpi_pkg::MODE_SWITCH_CYCLES);
    u_master.pins(1'b1, 1'b0);
    cyc(4);
    check({6'h00, twi_scl_out, twi_sda_out}, 8'h02, "pins forwarded");
    u_master.pins(1'b0, 1'b1);
    cyc(4);
    check({6'h00, twi_scl_out, twi_sda_out}, 8'h01, "pins forwarded");
    iface_sel_in = 1'b0;
    wait_for(1, 1'b0, shpi_pkg::MODE_SWITCH_CYCLES);
    cyc(4);
    // Data pin is still high here, so a leaking forward would show
    check({6'h00, twi_scl_out, twi_sda_out}, 8'h00, "pins parked in SPI mode");
    rd(1'b0, shpi_pkg::ADDR_TEMP_STAT, 8'h3c, "serial port back");
    give_verdict();
  end
endmodule : shpi_port_tb_top
